// >>> src/iie_pkg.sv
/*
  Shared constants, types and reset values for the I/O expander bus core.
  Assumes a 7-bit addressed two-wire bus and three 8-bit ports.
*/
// Functional notes
// [RULE1] Three 8-bit direction registers reset to all ones, so every pin starts as input.
// [RULE2] Direction one makes the pin an input, driver off; zero makes it an output.
// [RULE3] Low port supply holds the device in reset; release restores all defaults.
// [RULE4] Reset pin low forces registers and bus state machine to defaults.
// [RULE5] The controller holds the reset pin low at least the minimum pulse width.
// [RULE6] Any edge on an input-configured pin asserts the active-low interrupt.
// [RULE7] Interrupt clears on data returning, reading the causing port, or Stop.
// [RULE8] Read clear happens at the ACK or NACK bit after the rising clock edge.
// [RULE9] On Stop the interrupt is released after the rising data edge.
// [RULE10] After a clear every new input change raises the interrupt again.
// [RULE11] Traffic to other devices and output-configured pins never affect the interrupt.
// [RULE12] Switching output to input raises interrupt when pin differs from stored level.
// [RULE13] Interrupt output is open drain, only pulling low when asserted.
// [RULE14] A write is address with write bit, command byte, then data bytes.
// [RULE15] Any number of data bytes is accepted in one write.
// [RULE16] Twelve registers in four groups of three; pointer wraps third to first.
// [RULE17] A read is address plus command, repeated start, address with read bit.
// [RULE18] Repeated start keeps the register in progress as the new pointer.
// [RULE19] Each further read byte comes from the next register in the group.
// [RULE20] Read data is captured on the rising edge of the acknowledge clock.
// [RULE21] The master ends a read by not acknowledging the last byte.
// [RULE22] Input port registers show pin levels regardless of direction and ignore writes.
// [RULE23] Output port reads return the stored flip-flop value, not the pin.
// [RULE24] A set polarity bit inverts its pin in the input port register.
// [RULE25] After any reset the interrupt is released and the bus machine is idle.
package iie_pkg;
  localparam int NPORT     = 3;
  localparam int PW        = 8;
  localparam int CMD_PTR_W = 4;
  localparam int STOP_CW   = 4;

  localparam logic [6:0]         DEF_SLAVE_ADDR = 7'h22;
  localparam logic [STOP_CW-1:0] STOP_LAST      = 4'h7;
  localparam logic [STOP_CW-1:0] STOP_ONE       = 4'h1;
  localparam logic [1:0]         GRP_IN         = 2'h0;
  localparam logic [1:0]         GRP_OUT        = 2'h1;
  localparam logic [1:0]         GRP_POL        = 2'h2;
  localparam logic [1:0]         GRP_DIR        = 2'h3;
  localparam logic [1:0]         MEMB_FIRST     = 2'h0;
  localparam logic [1:0]         MEMB_LAST      = 2'h2;
  localparam logic [1:0]         MEMB_STEP      = 2'h1;
  localparam logic [2:0]         BIT_FIRST      = 3'h0;
  localparam logic [2:0]         BIT_ONE        = 3'h1;
  localparam logic [2:0]         BIT_LAST       = 3'h7;
  localparam logic [PW-1:0]      RST_OUT        = 8'hff;
  localparam logic [PW-1:0]      RST_POL        = 8'h00;
  localparam logic [PW-1:0]      RST_DIR        = 8'hff;
  localparam logic [PW-1:0]      RD_RSVD        = 8'h00;
  localparam logic               SDA_ACK        = 1'b0;

  typedef logic [NPORT-1:0][PW-1:0] iie_port_t;

  typedef struct packed {
    logic [1:0] grp;
    logic [1:0] memb;
  } iie_ptr_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'h0,
    S_ADDR = 4'h1,
    S_AACK = 4'h2,
    S_CMD  = 4'h3,
    S_CACK = 4'h4,
    S_WDAT = 4'h5,
    S_WACK = 4'h6,
    S_RDAT = 4'h7,
    S_RACK = 4'h8,
    S_SKIP = 4'h9
  } iie_bus_st_t;

  typedef struct packed {
    iie_port_t outp;
    iie_port_t pol;
    iie_port_t dir;
  } iie_regs_t;

  typedef struct packed {
    iie_bus_st_t st;
    logic [2:0]  cnt;
    logic [7:0]  shift;
    iie_ptr_t    ptr;
    logic        rw;
    logic        sel;
    logic        sda_pos;
  } iie_bus_t;

  typedef struct packed {
    logic sda_neg;
    logic sda_oe;
    logic sda_o;
  } iie_neg_t;

  typedef struct packed {
    logic               rst;
    logic               bus_rst;
    iie_port_t          ref_lvl;
    logic               int_oe;
    logic               int_o;
    iie_port_t          pin_oe;
    iie_port_t          pin_o;
    logic [STOP_CW-1:0] stop_cnt;
  } iie_main_t;

  localparam iie_regs_t REGS_RST = '{outp: {NPORT{RST_OUT}}, pol: {NPORT{RST_POL}}, dir: {NPORT{RST_DIR}}};
  localparam iie_bus_t  BUS_RST  = '{st: S_IDLE, cnt: BIT_FIRST, shift: '0, ptr: '0, rw: 1'b0, sel: 1'b0,
                                     sda_pos: 1'b1};
  localparam iie_neg_t  NEG_RST  = '{sda_neg: 1'b1, sda_oe: 1'b0, sda_o: 1'b0};
  localparam iie_main_t MAIN_RST = '{rst: 1'b1, bus_rst: 1'b1, ref_lvl: '0, int_oe: 1'b0, int_o: 1'b0,
                                     pin_oe: '0, pin_o: '0, stop_cnt: '0};

  // Next register inside the same group of three.
  function automatic iie_ptr_t iie_next_ptr(input iie_ptr_t p);
    iie_next_ptr.grp  = p.grp;
    iie_next_ptr.memb = (p.memb >= MEMB_LAST) ? MEMB_FIRST : p.memb + MEMB_STEP;
  endfunction
endpackage

// >>> src/iie_sync.sv
/*
  Two-stage level synchroniser for a bus of independent bits.
  Assumes each bit may be sampled on its own; no word coherence is given.
*/
`timescale 1ns/1ps
module iie_sync #(
  parameter int W = 1
) (
  input  wire logic         i_clk,
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);
  logic [W-1:0] meta_r;

  // The first stage feeds only the second one.
  always_ff @(posedge i_clk) begin
    meta_r <= i_d;
    o_q    <= meta_r;
  end
endmodule

// >>> src/iie_evt_x.sv
/*
  Event crossing by toggle: a pulse in the source domain becomes one pulse in the destination.
  Assumes source events are at least three destination cycles apart.
*/
`timescale 1ns/1ps
module iie_evt_x (
  input  wire logic i_src_clk,
  input  wire logic i_src_rst,
  input  wire logic i_src_pulse,
  input  wire logic i_dst_clk,
  input  wire logic i_dst_nrst,
  output logic      o_dst_pulse
);
  logic tgl_r;
  logic meta_r;
  logic sync_r;
  logic last_r;

  // Source toggle; the async reset only loads a constant.
  always_ff @(posedge i_src_clk or posedge i_src_rst) begin
    if (i_src_rst) begin
      tgl_r <= 1'b0;
    end else begin
      tgl_r <= tgl_r ^ i_src_pulse;
    end
  end

  // Destination: two stages, then an edge detector on the second stage only.
  always_ff @(posedge i_dst_clk) begin
    if (!i_dst_nrst) begin
      meta_r      <= 1'b0;
      sync_r      <= 1'b0;
      last_r      <= 1'b0;
      o_dst_pulse <= 1'b0;
    end else begin
      meta_r      <= tgl_r;
      sync_r      <= meta_r;
      last_r      <= sync_r;
      o_dst_pulse <= sync_r ^ last_r;
    end
  end
endmodule

// >>> src/iie_top.sv
/*
  Bus core of a 24-bit I/O expander: serial slave and registers on the bus clock,
  pin drive and the change interrupt on the system clock.
  Assumes reset is released while the bus is idle and the bus master keeps some data hold after clock falls.
*/
`timescale 1ns/1ps
module iie_top
  import iie_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = iie_pkg::DEF_SLAVE_ADDR
) (
  input  wire logic              i_clk,
  input  wire logic              i_nrst,
  input  wire logic              i_supply_ok,
  input  wire logic              i_scl,
  input  wire logic              i_sda,
  output logic                   o_sda_o,
  output logic                   o_sda_oe,
  input  wire iie_pkg::iie_port_t i_pin,
  output iie_pkg::iie_port_t     o_pin_o,
  output iie_pkg::iie_port_t     o_pin_oe,
  output logic                   o_int_o,
  output logic                   o_int_oe
);
  import iie_pkg::*;

  iie_main_t m_r;
  iie_main_t m_nxt;
  iie_regs_t g_r;
  iie_regs_t g_nxt;
  iie_bus_t  b_r;
  iie_bus_t  b_nxt;
  iie_neg_t  n_r;
  iie_neg_t  n_nxt;

  logic       dev_rst;
  logic       bus_rst;
  iie_port_t  pins_s;
  iie_port_t  pins_l;
  iie_port_t  outp_s;
  iie_port_t  dir_s;
  logic       supply_s;
  logic       scl_s;
  logic       sda_s;
  logic       pos_s;
  logic       sel_s;
  logic       stop_cond;
  logic       stop_fire;
  logic       start;
  logic       wr_fire;
  logic [7:0] shift_in;
  logic [NPORT-1:0] clr_l;
  logic [NPORT-1:0] clr_m;

  assign dev_rst = m_r.rst;
  assign bus_rst = m_r.bus_rst;

  // Outside levels into the system clock domain.
  iie_sync #(.W(NPORT * PW + 5)) u_sync_main (
    .i_clk (i_clk),
    .i_d   ({i_supply_ok, i_scl, i_sda, b_r.sda_pos, b_r.sel, i_pin}),
    .o_q   ({supply_s, scl_s, sda_s, pos_s, sel_s, pins_s})
  );

  // Configuration bits belong to independent pins, so per-bit crossing is safe.
  iie_sync #(.W(2 * NPORT * PW)) u_sync_cfg (
    .i_clk (i_clk),
    .i_d   ({g_r.outp, g_r.dir}),
    .o_q   ({outp_s, dir_s})
  );

  // Pin levels into the bus clock domain for input port reads.
  iie_sync #(.W(NPORT * PW)) u_sync_link (
    .i_clk (i_scl),
    .i_d   (i_pin),
    .o_q   (pins_l)
  );

  // Port read events travel to the interrupt logic as toggles.
  for (genvar p = 0; p < NPORT; p++) begin : g_clr
    iie_evt_x u_clr (
      .i_src_clk   (i_scl),
      .i_src_rst   (dev_rst),
      .i_src_pulse (clr_l[p]),
      .i_dst_clk   (i_clk),
      .i_dst_nrst  (i_nrst),
      .o_dst_pulse (clr_m[p])
    );
  end

  // Register read mux; reserved members answer zero.
  function automatic logic [7:0] rd_val(input iie_ptr_t p, input iie_regs_t g, input iie_port_t pins);
    rd_val = RD_RSVD;
    if (p.memb <= MEMB_LAST) begin
      unique case (p.grp)
        GRP_IN:  rd_val = pins[p.memb] ^ g.pol[p.memb]; // RULE22 RULE24
        GRP_OUT: rd_val = g.outp[p.memb]; // RULE23
        GRP_POL: rd_val = g.pol[p.memb];
        GRP_DIR: rd_val = g.dir[p.memb];
      endcase
    end
  endfunction

  // System domain: stop detection, interrupt compare and pin drive.
  // A stop is SDA high with SCL high after the last rising edge saw SDA low; the filter
  // rejects aliasing of a fast clock, at the cost of a few cycles of stop latency.
  always_comb begin
    m_nxt     = m_r;
    stop_cond = scl_s & sda_s & ~pos_s;
    stop_fire = stop_cond && (m_r.stop_cnt == STOP_LAST);
    m_nxt.stop_cnt = (stop_cond && !stop_fire) ? m_r.stop_cnt + STOP_ONE : '0;
    m_nxt.rst      = ~supply_s; // RULE3
    m_nxt.bus_rst  = ~supply_s | stop_fire;
    for (int p = 0; p < NPORT; p++) begin
      if (m_r.rst || clr_m[p] || (stop_fire && sel_s)) begin
        m_nxt.ref_lvl[p] = pins_s[p]; // RULE7 RULE8 RULE9 RULE10
      end else begin
        m_nxt.ref_lvl[p] = (m_r.ref_lvl[p] & dir_s[p]) | (pins_s[p] & ~dir_s[p]); // RULE12
      end
    end
    m_nxt.int_oe = ~m_r.rst & (|((pins_s ^ m_r.ref_lvl) & dir_s)); // RULE6 RULE11
    m_nxt.int_o  = 1'b0; // RULE13
    m_nxt.pin_oe = m_r.rst ? '0 : ~dir_s; // RULE2
    m_nxt.pin_o  = outp_s;
  end

  // Synchronous reset to defaults.
  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      m_r <= MAIN_RST; // RULE4 RULE25
    end else begin
      m_r <= m_nxt;
    end
  end

  // Bus domain: byte framing, pointer and register writes.
  // Start is seen as SDA high at the last rising edge and low at the following falling edge.
  always_comb begin
    b_nxt    = b_r;
    g_nxt    = g_r;
    clr_l    = '0;
    wr_fire  = 1'b0;
    shift_in = {b_r.shift[6:0], i_sda};
    start    = b_r.sda_pos & ~n_r.sda_neg;
    b_nxt.sda_pos = i_sda;
    if (start) begin
      b_nxt.st    = S_ADDR;
      b_nxt.shift = shift_in;
      b_nxt.cnt   = BIT_ONE;
      b_nxt.sel   = 1'b0;
    end else begin
      unique case (b_r.st)
        S_IDLE, S_SKIP: begin
          b_nxt.st = b_r.st;
        end
        S_ADDR, S_CMD, S_WDAT: begin
          b_nxt.shift = shift_in;
          b_nxt.cnt   = b_r.cnt + BIT_ONE;
          if (b_r.cnt == BIT_LAST) begin
            unique case (b_r.st)
              S_ADDR: begin
                if (shift_in[PW-1:1] == SLAVE_ADDR) begin
                  b_nxt.st  = S_AACK; // RULE14 RULE17
                  b_nxt.sel = 1'b1;
                  b_nxt.rw  = shift_in[0];
                end else begin
                  b_nxt.st = S_SKIP; // RULE11
                end
              end
              S_CMD: begin
                b_nxt.ptr = iie_ptr_t'(shift_in[CMD_PTR_W-1:0]);
                b_nxt.st  = S_CACK;
              end
              default: begin
                wr_fire   = 1'b1; // RULE15
                b_nxt.ptr = iie_next_ptr(b_r.ptr); // RULE16
                b_nxt.st  = S_WACK;
              end
            endcase
          end
        end
        S_AACK: begin
          b_nxt.cnt = BIT_FIRST;
          if (b_r.rw) begin
            b_nxt.shift = rd_val(b_r.ptr, g_r, pins_l); // RULE20 RULE18
            b_nxt.st    = S_RDAT;
          end else begin
            b_nxt.st = S_CMD;
          end
        end
        S_CACK, S_WACK: begin
          b_nxt.cnt = BIT_FIRST;
          b_nxt.st  = S_WDAT;
        end
        S_RDAT: begin
          b_nxt.shift = {b_r.shift[6:0], 1'b0};
          b_nxt.cnt   = b_r.cnt + BIT_ONE;
          if (b_r.cnt == BIT_LAST) begin
            b_nxt.st = S_RACK;
          end
        end
        S_RACK: begin
          if (b_r.ptr.grp == GRP_IN && b_r.ptr.memb <= MEMB_LAST) begin
            clr_l[b_r.ptr.memb] = 1'b1; // RULE8 RULE7
          end
          b_nxt.cnt = BIT_FIRST;
          if (i_sda == SDA_ACK) begin
            b_nxt.ptr   = iie_next_ptr(b_r.ptr); // RULE19
            b_nxt.shift = rd_val(iie_next_ptr(b_r.ptr), g_r, pins_l); // RULE20
            b_nxt.st    = S_RDAT;
          end else begin
            b_nxt.st = S_SKIP; // RULE21
          end
        end
        default: begin
          b_nxt.st = S_IDLE;
        end
      endcase
    end
    // Writes to input ports and reserved members are dropped.
    if (wr_fire && b_r.ptr.memb <= MEMB_LAST) begin
      unique case (b_r.ptr.grp)
        GRP_OUT: g_nxt.outp[b_r.ptr.memb] = shift_in;
        GRP_POL: g_nxt.pol[b_r.ptr.memb]  = shift_in;
        GRP_DIR: g_nxt.dir[b_r.ptr.memb]  = shift_in; // RULE1 RULE2
        GRP_IN:  g_nxt.dir                = g_r.dir; // RULE22
      endcase
    end
  end

  // Registers leave reset only with the device; bus stop does not touch them.
  always_ff @(posedge i_scl or posedge dev_rst) begin
    if (dev_rst) begin
      g_r <= REGS_RST; // RULE1 RULE3 RULE4
    end else begin
      g_r <= g_nxt;
    end
  end

  // The bus machine also returns to idle on every stop.
  always_ff @(posedge i_scl or posedge bus_rst) begin
    if (bus_rst) begin
      b_r <= BUS_RST; // RULE25
    end else begin
      b_r <= b_nxt;
    end
  end

  // Data is driven on the falling edge so it is stable before the master samples.
  always_comb begin
    n_nxt         = n_r;
    n_nxt.sda_neg = i_sda;
    n_nxt.sda_o   = 1'b0;
    n_nxt.sda_oe  = (b_r.st == S_AACK) || (b_r.st == S_CACK) || (b_r.st == S_WACK) ||
                    ((b_r.st == S_RDAT) && !b_r.shift[PW-1]);
  end

  always_ff @(negedge i_scl or posedge bus_rst) begin
    if (bus_rst) begin
      n_r <= NEG_RST;
    end else begin
      n_r <= n_nxt;
    end
  end

  assign o_sda_o  = n_r.sda_o;
  assign o_sda_oe = n_r.sda_oe;
  assign o_pin_o  = m_r.pin_o;
  assign o_pin_oe = m_r.pin_oe;
  assign o_int_o  = m_r.int_o;
  assign o_int_oe = m_r.int_oe;

  // Checks in the system domain.
  a_int_raise: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (!m_r.rst && |((pins_s ^ m_r.ref_lvl) & dir_s)) |=> o_int_oe) // RULE6
    else $error("input change did not raise interrupt");
  a_out_quiet: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (~|((pins_s ^ m_r.ref_lvl) & dir_s)) |=> !o_int_oe) // RULE11
    else $error("interrupt without input mismatch");
  a_reset_defaults: assert property (@(posedge i_clk)
    (!i_nrst) |=> (o_pin_oe == '0 && !o_int_oe)) // RULE4
    else $error("outputs not at default after reset");
  a_supply_hold: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (!supply_s) |=> ##1 (o_pin_oe == '0 && !o_int_oe)) // RULE3
    else $error("pins driven while supply low");
  a_stop_clear: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (stop_fire && sel_s && !m_r.rst) |=> (m_r.ref_lvl == $past(pins_s))) // RULE9
    else $error("stop did not reload reference");
  a_read_clear: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (clr_m[0] && !m_r.rst) |=> (m_r.ref_lvl[0] == $past(pins_s[0]))) // RULE7
    else $error("port read did not clear interrupt");
  a_dir_drive: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (!m_r.rst) |=> (o_pin_oe == ~$past(dir_s))) // RULE2
    else $error("pin drive does not follow direction");
  a_int_od: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (!o_int_o) [*2]) // RULE13
    else $error("interrupt pin driven high");

  // Checks in the bus domain.
  a_wr_advance: assert property (@(posedge i_scl) disable iff (bus_rst)
    (wr_fire && !start) |=> (b_r.ptr == iie_next_ptr($past(b_r.ptr)))) // RULE16
    else $error("write pointer did not advance in group");
  a_addr_ack: assert property (@(posedge i_scl) disable iff (bus_rst)
    (b_r.st == S_AACK) |-> o_sda_oe) // RULE14
    else $error("address not acknowledged");
  a_rd_capture: assert property (@(posedge i_scl) disable iff (bus_rst)
    (b_r.st == S_AACK && b_r.rw && !start) |=> (b_r.shift == $past(rd_val(b_r.ptr, g_r, pins_l)))) // RULE20
    else $error("read data not captured at acknowledge");
  a_in_readonly: assert property (@(posedge i_scl) disable iff (bus_rst)
    (wr_fire && b_r.ptr.grp == GRP_IN) |=> $stable(g_r)) // RULE22
    else $error("write changed registers via input port");

  c_write: cover property (@(posedge i_scl) disable iff (bus_rst) wr_fire);
  c_read_more: cover property (@(posedge i_scl) disable iff (bus_rst) (b_r.st == S_RACK && i_sda == SDA_ACK));
  c_int_stop: cover property (@(posedge i_clk) disable iff (!i_nrst) (o_int_oe && stop_fire && sel_s));
endmodule

// >>> test/iie_bus_master.sv
/*
  Behavioural two-wire bus master that makes the serial clock and pulls the data line.
  Assumes the data line is resolved outside with a pull-up, and that the clock stands high between frames.
*/
`timescale 1ns/1ps
module iie_bus_master (
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_pull
);
  logic [7:0] rd_val;
  int         nacks;
  int         gap;
  event       rd_ev;

  // Idle bus: clock high, data released to its pull-up.
  initial begin
    o_scl      = 1'b1;
    o_sda_pull = 1'b0;
    nacks      = 0;
    gap        = 100;
  end

  // One bit of a 6 ns clock; data moves 1 ns after the fall so a start is never faked.
  task automatic bit_x(input logic b, output logic r);
    #1 o_sda_pull = ~b;
    #2 o_scl = 1'b1;
    #1 r = i_sda;
    #2 o_scl = 1'b0;
  endtask

  // Start or repeated start: data falls while the clock is high.
  task automatic start();
    if (!o_scl) begin
      #1 o_sda_pull = 1'b0;
      #2 o_scl = 1'b1;
    end
    #3 o_sda_pull = 1'b1;
    #3 o_scl = 1'b0;
  endtask

  // Stop, then idle long enough for the system-side stop filter to see it.
  task automatic stop();
    #1 o_sda_pull = 1'b1;
    #2 o_scl = 1'b1;
    #3 o_sda_pull = 1'b0;
    #400;
  endtask

  // The low pause after each byte spaces the events that cross to the system clock.
  task automatic wr_byte(input logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(v[i], r);
    bit_x(1'b1, r);
    if (r !== 1'b0) nacks++;
    #gap;
  endtask

  task automatic rd_byte(input logic last);
    logic [7:0] v;
    logic       r;
    for (int i = 7; i >= 0; i--) bit_x(1'b1, v[i]);
    bit_x(last, r);
    rd_val = v;
    -> rd_ev;
    #gap;
  endtask

  task automatic write_seq(input logic [6:0] a, input logic [7:0] cmd, input logic [7:0] dq[$]);
    start();
    wr_byte({a, 1'b0});
    wr_byte(cmd);
    foreach (dq[i]) wr_byte(dq[i]);
    stop();
  endtask

  task automatic read_seq(input logic [6:0] a, input logic [7:0] cmd, input int n);
    start();
    wr_byte({a, 1'b0});
    wr_byte(cmd);
    start();
    wr_byte({a, 1'b1});
    for (int i = 1; i <= n; i++) rd_byte(i == n);
    stop();
  endtask
endmodule

// >>> test/iie_top_tb.sv
/*
  Self-checking bench for the expander bus core: registers, pins, resets and the change interrupt.
  Assumes the design package and the bus master model are compiled before it.
*/
`timescale 1ns/1ps
module iie_top_tb;
  import iie_pkg::*;
  localparam logic [6:0] ADDR  = 7'h22;
  localparam int         LIMIT = 6000;
  logic       clk, nrst, supply_ok, scl, pull, sda, sda_o, sda_oe, int_o, int_oe;
  iie_port_t  pin, pin_o, pin_oe, ext, dv, ov, pv, ev;
  logic [7:0] a, b, c, d, exp_q[$];
  int         mismatches, tests_run, cycles, n0;

  // Open-drain data line with pull-up; pins follow their driver when enabled.
  assign sda = ~(pull | sda_oe);
  assign pin = (pin_oe & pin_o) | (~pin_oe & ext);

  iie_top #(.SLAVE_ADDR(ADDR)) iie_top_i (.i_clk(clk), .i_nrst(nrst), .i_supply_ok(supply_ok), .i_scl(scl),
    .i_sda(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe), .i_pin(pin), .o_pin_o(pin_o), .o_pin_oe(pin_oe),
    .o_int_o(int_o), .o_int_oe(int_oe));
  iie_bus_master mst (.i_sda(sda), .o_scl(scl), .o_sda_pull(pull));

  // System clock at 40 MHz.
  initial clk = 1'b0;
  always #12.5 clk = ~clk;

  task automatic fail(input string msg);
    mismatches++;
    $display("CHECK FAILED t=%0t %s", $time, msg);
  endtask

  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string msg);
    tests_run++;
    if (got !== exp) fail(msg);
  endtask

  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // A hang is cut short here and still reaches the closing report.
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fail("timeout");
      tally_and_finish();
    end
  end

  // Each byte the master reads is matched with the oldest expectation.
  always @(mst.rd_ev) begin
    if (exp_q.size() == 0) fail("unexpected read byte");
    else chk(mst.rd_val, exp_q.pop_front(), "read byte");
  end

  // Inputs set right after this task change 1 ns after a rising edge.
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic rd(input logic [7:0] cmd, input logic [7:0] e[$]);
    foreach (e[i]) exp_q.push_back(e[i]);
    mst.read_seq(ADDR, cmd, e.size());
  endtask

  task automatic flip(input int p, input int k);
    tick(1);
    ext[p][k] = ~ext[p][k];
  endtask

  // The interrupt answers within a few cycles; twenty is a generous bound.
  task automatic wait_int(input logic v, input string msg);
    for (int i = 0; i < 20 && int_oe !== v; i++) tick(1);
    chk(int_oe, v, msg);
  endtask

  task automatic start_read(input logic [7:0] cmd);
    mst.start();
    mst.wr_byte({ADDR, 1'b0});
    mst.wr_byte(cmd);
    mst.start();
    mst.wr_byte({ADDR, 1'b1});
  endtask

  initial begin
    nrst = 1'b0;
    supply_ok = 1'b1;
    ext = '0;
    mismatches = 0;
    tests_run = 0;
    cycles = 0;
    a = 8'($urandom(32'h3879));
    tick(5);
    nrst = 1'b1;
    tick(3);
    // Defaults after reset, with a fourth byte to see the group wrap.
    chk(pin_oe, '0, "pins not inputs");
    chk(int_oe, 1'b0, "interrupt after reset");
    rd(8'h0c, '{8'hff, 8'hff, 8'hff, 8'hff});
    rd(8'h08, '{8'h00, 8'h00, 8'h00});
    // Four bytes starting at the third output register wrap to the first.
    a = 8'($urandom);
    b = 8'($urandom);
    c = 8'($urandom);
    d = 8'($urandom);
    mst.write_seq(ADDR, 8'h06, '{a, b, c, d});
    ov = {d, c, b};
    rd(8'h04, '{b, c, d, b});
    chk(pin_o, ov, "output latches");
    // Mixed directions and random polarity; input ports see every pin.
    dv = {8'hff, 8'hf0, 8'h0f};
    pv = 24'($urandom);
    ext = 24'($urandom);
    mst.write_seq(ADDR, 8'h0c, '{dv[0], dv[1], dv[2]});
    mst.write_seq(ADDR, 8'h08, '{pv[0], pv[1], pv[2]});
    tick(4);
    chk(pin_oe, ~dv, "drive enables");
    ev = ((~dv & ov) | (dv & ext)) ^ pv;
    mst.gap = 300;
    rd(8'h00, '{ev[0], ev[1], ev[2]});
    mst.gap = 100;
    mst.write_seq(ADDR, 8'h00, '{~ev[0]});
    rd(8'h00, '{ev[0]});
    rd(8'h03, '{8'h00});
    // A repeated start resumes at the register that was being read.
    exp_q = '{ev[1], ev[2], ev[2]};
    start_read(8'h01);
    mst.rd_byte(1'b0);
    mst.rd_byte(1'b1);
    mst.start();
    mst.wr_byte({ADDR, 1'b1});
    mst.rd_byte(1'b1);
    mst.stop();
    // Interrupt raise, return, re-raise and clear by reading the port.
    mst.write_seq(ADDR, 8'h0c, '{8'hff, 8'hff, 8'hff});
    mst.write_seq(ADDR, 8'h08, '{8'h00, 8'h00, 8'h00});
    tick(4);
    chk(int_oe, 1'b0, "quiet after stop");
    flip(0, 3);
    wait_int(1'b1, "edge raises");
    chk(int_o, 1'b0, "open drain level");
    chk(sda_o, 1'b0, "data line drive level");
    flip(0, 3);
    wait_int(1'b0, "return clears");
    flip(1, 0);
    wait_int(1'b1, "raised again");
    exp_q.push_back(ext[1]);
    start_read(8'h01);
    mst.rd_byte(1'b1);
    tick(10);
    chk(int_oe, 1'b0, "read clears before stop");
    mst.stop();
    // Traffic to another device leaves it set; a stop of ours clears it.
    flip(2, 7);
    wait_int(1'b1, "raised for stop test");
    n0 = mst.nacks;
    mst.start();
    mst.wr_byte({ADDR ^ 7'h01, 1'b0});
    mst.stop();
    chk(mst.nacks, n0 + 1, "other address acked");
    tick(20);
    chk(int_oe, 1'b1, "other traffic cleared");
    mst.write_seq(ADDR, 8'h05, '{});
    wait_int(1'b0, "stop clears");
    // Output pins never interrupt; turning one back to input may.
    mst.write_seq(ADDR, 8'h0e, '{8'h00});
    mst.write_seq(ADDR, 8'h06, '{8'h5a});
    tick(20);
    chk(int_oe, 1'b0, "output pin raised");
    ext[2] = 8'ha5;
    mst.start();
    mst.wr_byte({ADDR, 1'b0});
    mst.wr_byte(8'h0e);
    mst.wr_byte(8'hff);
    wait_int(1'b1, "false interrupt missing");
    mst.stop();
    // Supply drop and reset pin restore the defaults.
    tick(1);
    supply_ok = 1'b0;
    tick(5);
    supply_ok = 1'b1;
    tick(4);
    rd(8'h04, '{8'hff, 8'hff, 8'hff});
    mst.write_seq(ADDR, 8'h0c, '{8'h00});
    flip(1, 1);
    tick(1);
    nrst = 1'b0;
    tick(5);
    nrst = 1'b1;
    tick(3);
    chk(pin_oe, '0, "reset pin drive");
    chk(int_oe, 1'b0, "reset pin interrupt");
    rd(8'h0c, '{8'hff});
    chk(exp_q.size(), 0, "reads missing");
    tally_and_finish();
  end
endmodule
